// [rtl/itac_pkg.sv]
// Constants and types shared by the transmit-abort cause block
package itac_pkg;
	localparam int ITAC_ADDR_W = 32;
	localparam int ITAC_DATA_W = 32;
	localparam int ITAC_CAUSE_W = 16;
	localparam int ITAC_IRQ_W = 2;
	// Byte addresses of the registers
	localparam logic [31:0] OFF_CONFIG = 32'h5000_1300;
	localparam logic [31:0] OFF_TARGET = 32'h5000_1304;
	localparam logic [31:0] OFF_CAUSE = 32'h5000_1380;
	localparam logic [31:0] OFF_CLEAR = 32'h5000_1384;
	localparam logic [31:0] OFF_IRQ_STAT = 32'h5000_1388;
	localparam logic [31:0] OFF_IRQ_MASK = 32'h5000_138c;
	// Cause flag positions
	localparam int BIT_SEVENBIT_NACK = 0;
	localparam int BIT_TENBIT_FIRST_NACK = 1;
	localparam int BIT_TENBIT_SECOND_NACK = 2;
	localparam int BIT_TX_DATA_NACK = 3;
	localparam int BIT_GCALL_NACK = 4;
	localparam int BIT_GCALL_READ = 5;
	localparam int BIT_HS_CODE_ACKED = 6;
	localparam int BIT_STARTBYTE_ACKED = 7;
	localparam int BIT_HS_NO_RESTART = 8;
	localparam int BIT_STARTBYTE_NO_RESTART = 9;
	localparam int BIT_ARBITRATION_LOST_FLAG = 12;
	localparam logic [15:0] CAUSE_IMPL_MASK = 16'h13ff;
	localparam logic [15:0] CAUSE_RST = 16'h0000;
	// Configuration and target fields
	localparam int CFG_RESTART_BIT = 5;
	localparam int CFG_SPEED_LSB = 1;
	localparam logic [1:0] SPEED_HS = 2'h3;
	localparam logic [15:0] CONFIG_RST = 16'h0000;
	localparam int TAR_SEL_BIT = 11;
	localparam int TAR_PICK_BIT = 10;
	localparam logic [15:0] TARGET_RST = 16'h0000;
	// Interrupt status bits
	localparam int IRQ_ABORT = 0;
	localparam int IRQ_ARB = 1;
	localparam logic [1:0] IRQ_RST = 2'h0;
	// Bus phase whose acknowledge the master engine reports
	typedef enum logic [2:0] {
		PH_ADDR7,
		PH_ADDR10_FIRST,
		PH_ADDR10_SECOND,
		PH_GCALL,
		PH_STARTBYTE,
		PH_HS_CODE,
		PH_DATA
	} itac_phase_t;
endpackage

// [rtl/itac_flag_if.sv]
// Set, clear and value of a bank of sticky flags
`timescale 1ns/1ps
interface itac_flag_if #(parameter int W = 16);
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic [W-1:0] q;
	modport bank (input set, input clr, output q);
	modport ctrl (output set, output clr, input q);
endinterface

// [rtl/itac_sticky_bank.sv]
// Bank of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/1ps
module itac_sticky_bank import itac_pkg::*; #(
	parameter int W = 16,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic core_clk_i, // Controller clock
	input wire logic rst_b_i, // Asynchronous reset, active low
	itac_flag_if.bank flags // Set, clear and value
);
	generate
		if (W < 1) begin : g_bad_width
			$error("itac_sticky_bank: W must be at least 1");
		end
	endgenerate

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flags.q <= RST;
		end else begin
			flags.q <= (flags.q & ~flags.clr) | flags.set;
		end
	end
endmodule

// [rtl/itac_cause_detect.sv]
// Turns master engine reports and restart/arbitration levels into abort cause set requests
`timescale 1ns/1ps
module itac_cause_detect import itac_pkg::*; (
	input wire logic cmd_pending_i, // Master has a command queued
	input wire logic restart_allow_i, // Restart conditions allowed
	input wire logic hs_mode_i, // High Speed mode selected
	input wire logic startbyte_sel_i, // Target asks for a START byte
	input wire logic ack_valid_i, // Acknowledge report strobe
	input wire itac_phase_t ack_phase_i, // Phase of the report
	input wire logic acked_i, // Report saw an acknowledge
	input wire logic addr_acked_i, // Address of this transfer acked
	input wire logic next_cmd_read_i, // Next queued command is a read
	input wire logic arbitration_lost_flag_i, // Master or slave lost the bus
	output logic [ITAC_CAUSE_W-1:0] set_o // Cause set requests
);
	wire rep_nack = ack_valid_i && !acked_i;
	wire rep_ack = ack_valid_i && acked_i;

	always_comb begin
		set_o = '0;
		set_o[BIT_STARTBYTE_NO_RESTART] = cmd_pending_i && startbyte_sel_i && !restart_allow_i; // RULE_01
		set_o[BIT_HS_NO_RESTART] = cmd_pending_i && hs_mode_i && !restart_allow_i; // RULE_05
		set_o[BIT_STARTBYTE_ACKED] = rep_ack && ack_phase_i == PH_STARTBYTE; // RULE_06
		set_o[BIT_HS_CODE_ACKED] = rep_ack && ack_phase_i == PH_HS_CODE; // RULE_07
		set_o[BIT_GCALL_READ] = rep_ack && ack_phase_i == PH_GCALL && next_cmd_read_i; // RULE_08
		set_o[BIT_GCALL_NACK] = rep_nack && ack_phase_i == PH_GCALL; // RULE_09
		set_o[BIT_TX_DATA_NACK] = rep_nack && ack_phase_i == PH_DATA && addr_acked_i; // RULE_10
		set_o[BIT_TENBIT_SECOND_NACK] = rep_nack && ack_phase_i == PH_ADDR10_SECOND; // RULE_11
		set_o[BIT_TENBIT_FIRST_NACK] = rep_nack && ack_phase_i == PH_ADDR10_FIRST; // RULE_12
		set_o[BIT_SEVENBIT_NACK] = rep_nack && ack_phase_i == PH_ADDR7; // RULE_13
		set_o[BIT_ARBITRATION_LOST_FLAG] = arbitration_lost_flag_i; // RULE_14
	end
endmodule

// [rtl/itac_top.sv]
// Transmit-abort cause flags with register port and interrupt
// Function
// RULE_01: Set flag 9 while a START byte is requested with restart disabled.
// RULE_02: Clearing flag 9 with its cause present drops it one cycle, then resets it.
// RULE_03: Software removes the flag 9 cause before clearing it.
// RULE_04: Once the cause is gone, flag 9 clears like every other flag.
// RULE_05: Set flag 8 when High Speed transfer is requested with restart disabled.
// RULE_06: Set flag 7 when a sent START byte is acknowledged.
// RULE_07: Set flag 6 when the High Speed master code is acknowledged.
// RULE_08: Set flag 5 when General Call is followed by a queued read command.
// RULE_09: Set flag 4 when no slave acknowledges a General Call.
// RULE_10: Set flag 3 when a data byte after an acked address is not acked.
// RULE_11: Set flag 2 when the second 10-bit address byte is not acked.
// RULE_12: Set flag 1 when the first 10-bit address byte is not acked.
// RULE_13: Set flag 0 when a 7-bit address is not acked.
// RULE_14: Set flag 12 when master or slave transmitter loses arbitration.
// RULE_15: Flags reset to zero and ignore direct software writes.
`timescale 1ns/1ps
module itac_top import itac_pkg::*; (
	input wire logic core_clk_i, // Controller clock, 250 MHz
	input wire logic rst_b_i, // Asynchronous reset, active low
	input wire logic [ITAC_ADDR_W-1:0] addr_i, // Register byte address
	input wire logic [ITAC_DATA_W-1:0] wr_data_i, // Register write data
	input wire logic wr_en_i, // Register write strobe
	input wire logic rd_en_i, // Register read strobe
	output logic [ITAC_DATA_W-1:0] rd_data_o, // Read data, cycle after strobe
	input wire logic cmd_pending_i, // Master has a command queued
	input wire logic start_req_i, // Master begins a new transfer
	input wire logic ack_valid_i, // Acknowledge report strobe
	input wire itac_phase_t ack_phase_i, // Phase of the report
	input wire logic acked_i, // Report saw an acknowledge
	input wire logic next_cmd_read_i, // Next queued command is a read
	input wire logic mst_arbitration_lost_flag_i, // Master lost arbitration
	input wire logic slv_arbitration_lost_flag_i, // Slave transmitter lost the bus
	output logic restart_allow_o, // Restart conditions allowed
	output logic hs_mode_o, // High Speed mode selected
	output logic startbyte_sel_o, // Target asks for a START byte
	output logic tx_abort_o, // Pulse: a new abort cause was set
	output logic [ITAC_CAUSE_W-1:0] abort_cause_o, // Current cause flags
	output logic irq_o // Level interrupt
);
	logic [15:0] controller_config;
	logic [15:0] target_address_reg;
	logic [ITAC_IRQ_W-1:0] irq_mask;
	logic [ITAC_DATA_W-1:0] rd_data;
	logic tx_abort;
	logic addr_acked;
	logic [ITAC_CAUSE_W-1:0] det_set;

	itac_flag_if #(.W(ITAC_CAUSE_W)) cause_if ();
	itac_flag_if #(.W(ITAC_IRQ_W)) irq_if ();

	// Register decode
	wire sel_config = addr_i == OFF_CONFIG;
	wire sel_target = addr_i == OFF_TARGET;
	wire sel_cause = addr_i == OFF_CAUSE;
	wire sel_clear = addr_i == OFF_CLEAR;
	wire sel_irq_stat = addr_i == OFF_IRQ_STAT;
	wire sel_irq_mask = addr_i == OFF_IRQ_MASK;
	wire wr_config = wr_en_i && sel_config;
	wire wr_target = wr_en_i && sel_target;
	wire wr_clear = wr_en_i && sel_clear;
	wire wr_irq_stat = wr_en_i && sel_irq_stat;
	wire wr_irq_mask = wr_en_i && sel_irq_mask;

	// Control fields
	wire restart_allow = controller_config[CFG_RESTART_BIT];
	wire hs_mode = controller_config[CFG_SPEED_LSB+1:CFG_SPEED_LSB] == SPEED_HS;
	wire startbyte_sel = target_address_reg[TAR_SEL_BIT] && target_address_reg[TAR_PICK_BIT];
	wire mst_ack_addr = ack_valid_i && acked_i
		&& (ack_phase_i == PH_ADDR7 || ack_phase_i == PH_ADDR10_SECOND);

	itac_cause_detect u_detect (
		.cmd_pending_i(cmd_pending_i),
		.restart_allow_i(restart_allow),
		.hs_mode_i(hs_mode),
		.startbyte_sel_i(startbyte_sel),
		.ack_valid_i(ack_valid_i),
		.ack_phase_i(ack_phase_i),
		.acked_i(acked_i),
		.addr_acked_i(addr_acked),
		.next_cmd_read_i(next_cmd_read_i),
		.arbitration_lost_flag_i(mst_arbitration_lost_flag_i || slv_arbitration_lost_flag_i),
		.set_o(det_set)
	);

	// Write-one-to-clear on implemented flags only; the cause register itself ignores writes
	wire [ITAC_CAUSE_W-1:0] cause_clr = wr_clear ? (wr_data_i[ITAC_CAUSE_W-1:0] & CAUSE_IMPL_MASK)
		: '0; // RULE_04 RULE_15
	// Flag 9 is a level cause: a clear wins for that cycle and the cause sets it again next cycle
	wire [ITAC_CAUSE_W-1:0] cause_set = det_set
		& ~(cause_clr & (ITAC_CAUSE_W'(1) << BIT_STARTBYTE_NO_RESTART)); // RULE_02
	wire [ITAC_CAUSE_W-1:0] new_cause = cause_set & ~cause_if.q;
	wire new_abort = |(new_cause & ~(ITAC_CAUSE_W'(1) << BIT_ARBITRATION_LOST_FLAG));

	assign cause_if.set = cause_set;
	assign cause_if.clr = cause_clr;
	assign irq_if.set = {new_cause[BIT_ARBITRATION_LOST_FLAG], new_abort};
	assign irq_if.clr = wr_irq_stat ? wr_data_i[ITAC_IRQ_W-1:0] : '0;

	itac_sticky_bank #(.W(ITAC_CAUSE_W), .RST(CAUSE_RST)) u_cause (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.flags(cause_if)
	);

	itac_sticky_bank #(.W(ITAC_IRQ_W), .RST(IRQ_RST)) u_irq (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.flags(irq_if)
	);

	// Read selection; unmapped addresses read zero
	wire [ITAC_DATA_W-1:0] next_rd_data =
		sel_config ? {16'h0000, controller_config} :
		sel_target ? {16'h0000, target_address_reg} :
		sel_cause ? {16'h0000, cause_if.q} :
		sel_irq_stat ? {30'h0000_0000, irq_if.q} :
		sel_irq_mask ? {30'h0000_0000, irq_mask} :
		32'h0000_0000;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			controller_config <= CONFIG_RST;
			target_address_reg <= TARGET_RST;
			irq_mask <= IRQ_RST;
		end else begin
			if (wr_config) begin
				controller_config <= wr_data_i[15:0];
			end
			if (wr_target) begin
				target_address_reg <= wr_data_i[15:0];
			end
			if (wr_irq_mask) begin
				irq_mask <= wr_data_i[ITAC_IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_data <= 32'h0000_0000;
			tx_abort <= 1'b0;
		end else begin
			rd_data <= rd_en_i ? next_rd_data : 32'h0000_0000;
			tx_abort <= |new_cause;
		end
	end

	// Tracks whether the address of the current transfer was acknowledged
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			addr_acked <= 1'b0;
		end else if (start_req_i) begin
			addr_acked <= 1'b0;
		end else if (mst_ack_addr) begin
			addr_acked <= 1'b1; // RULE_10
		end
	end

	assign rd_data_o = rd_data;
	assign restart_allow_o = restart_allow;
	assign hs_mode_o = hs_mode;
	assign startbyte_sel_o = startbyte_sel;
	assign tx_abort_o = tx_abort;
	assign abort_cause_o = cause_if.q;
	assign irq_o = |(irq_if.q & irq_mask);

	// Checks
	wire sbyte_cause = cmd_pending_i && startbyte_sel && !restart_allow;
	wire hs_cause = cmd_pending_i && hs_mode && !restart_allow;
	wire clr9 = wr_clear && wr_data_i[BIT_STARTBYTE_NO_RESTART];

	chk_sbyte_norestart_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_01
		sbyte_cause && !clr9 |=> abort_cause_o[BIT_STARTBYTE_NO_RESTART])
		else $error("flag 9 not set by START byte request without restart");

	chk_sbyte_clear_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_02
		clr9 && sbyte_cause ##1 sbyte_cause && !clr9
		|-> !abort_cause_o[BIT_STARTBYTE_NO_RESTART] ##1 abort_cause_o[BIT_STARTBYTE_NO_RESTART])
		else $error("flag 9 did not drop one cycle and reassert");

	chk_sbyte_clear_fixed: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_04
		clr9 && !sbyte_cause |=> !abort_cause_o[BIT_STARTBYTE_NO_RESTART])
		else $error("flag 9 not cleared after cause removed");

	chk_hs_norestart_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_05
		hs_cause |=> abort_cause_o[BIT_HS_NO_RESTART])
		else $error("flag 8 not set by High Speed request without restart");

	chk_sbyte_ack_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_06
		ack_valid_i && acked_i && ack_phase_i == PH_STARTBYTE
		|=> abort_cause_o[BIT_STARTBYTE_ACKED] && tx_abort_o || $past(abort_cause_o[BIT_STARTBYTE_ACKED]))
		else $error("acknowledged START byte not flagged");

	chk_hs_code_ack: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_07
		ack_valid_i && acked_i && ack_phase_i == PH_HS_CODE |=> abort_cause_o[BIT_HS_CODE_ACKED])
		else $error("acknowledged High Speed code not flagged");

	chk_gcall_read_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_08
		ack_valid_i && acked_i && ack_phase_i == PH_GCALL
		|=> abort_cause_o[BIT_GCALL_READ] == ($past(next_cmd_read_i) || $past(abort_cause_o[BIT_GCALL_READ])))
		else $error("General Call read flag wrong");

	chk_gcall_nack_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_09
		ack_valid_i && !acked_i && ack_phase_i == PH_GCALL |=> abort_cause_o[BIT_GCALL_NACK])
		else $error("unacknowledged General Call not flagged");

	chk_data_nack_gate: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_10
		!abort_cause_o[BIT_TX_DATA_NACK] && !(ack_valid_i && ack_phase_i == PH_DATA && addr_acked)
		|=> !abort_cause_o[BIT_TX_DATA_NACK])
		else $error("data nack flag set without acked address");

	chk_tenbit_second: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_11
		ack_valid_i && !acked_i && ack_phase_i == PH_ADDR10_SECOND
		|=> abort_cause_o[BIT_TENBIT_SECOND_NACK])
		else $error("second 10-bit byte nack not flagged");

	chk_tenbit_first: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_12
		ack_valid_i && !acked_i && ack_phase_i == PH_ADDR10_FIRST
		|=> abort_cause_o[BIT_TENBIT_FIRST_NACK])
		else $error("first 10-bit byte nack not flagged");

	chk_sevenbit_nack: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_13
		ack_valid_i && !acked_i && ack_phase_i == PH_ADDR7 |=> abort_cause_o[BIT_SEVENBIT_NACK])
		else $error("7-bit address nack not flagged");

	chk_arbitration_lost_flag_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_14
		mst_arbitration_lost_flag_i || slv_arbitration_lost_flag_i |=> abort_cause_o[BIT_ARBITRATION_LOST_FLAG] ##0 irq_if.q[IRQ_ARB])
		else $error("arbitration loss not flagged");

	chk_cause_no_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_15
		wr_en_i && sel_cause && det_set == '0 |=> abort_cause_o == $past(abort_cause_o))
		else $error("abort cause changed by direct write");

	chk_unimpl_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE_15
		(abort_cause_o & ~CAUSE_IMPL_MASK) == '0)
		else $error("unimplemented cause bit set");

	chk_irq_level: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		new_abort && irq_mask[IRQ_ABORT] |=> irq_o [*2])
		else $error("interrupt not raised for masked-in abort");

	cov_sbyte_recover: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
		clr9 && sbyte_cause ##1 !abort_cause_o[BIT_STARTBYTE_NO_RESTART] ##1 abort_cause_o[BIT_STARTBYTE_NO_RESTART]);
	cov_data_nack: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
		mst_ack_addr ##[1:20] ack_valid_i && !acked_i && ack_phase_i == PH_DATA);
	cov_set_beats_clear: cover property (@(posedge core_clk_i) disable iff (!rst_b_i)
		wr_clear && |(det_set & cause_clr & ~(ITAC_CAUSE_W'(1) << BIT_STARTBYTE_NO_RESTART)));
	cov_irq: cover property (@(posedge core_clk_i) disable iff (!rst_b_i) irq_o);
endmodule

// [verification/itac_slave_model.sv]
// Remote slave that answers the master's acknowledge phases
`timescale 1ns/1ps
module itac_slave_model import itac_pkg::*; (
	input wire logic core_clk_i, // Controller clock
	input wire logic rst_b_i, // Asynchronous reset, active low
	input wire logic req_i, // One-cycle request for a phase answer
	input wire itac_phase_t phase_i, // Phase to answer
	input wire logic ack_i, // Slave acknowledges this phase
	input wire logic slow_i, // Answer three cycles later
	output logic ack_valid_o, // Report strobe
	output itac_phase_t ack_phase_o, // Reported phase
	output logic acked_o // Acknowledge seen
);
	int wait_cnt;
	logic pend;
	logic ack_hold;
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend <= 1'b0;
			wait_cnt <= 0;
			ack_hold <= 1'b0;
			ack_valid_o <= 1'b0;
			ack_phase_o <= PH_ADDR7;
			acked_o <= 1'b0;
		end else begin
			ack_valid_o <= 1'b0;
			// Line is not held outside a report
			acked_o <= ~acked_o;
			if (req_i) begin
				pend <= 1'b1;
				wait_cnt <= slow_i ? 3 : 0;
				ack_phase_o <= phase_i;
				ack_hold <= ack_i;
			end else if (pend && wait_cnt != 0) begin
				wait_cnt <= wait_cnt - 1;
			end else if (pend) begin
				pend <= 1'b0;
				ack_valid_o <= 1'b1;
				acked_o <= ack_hold;
			end
		end
	end
endmodule

// [verification/itac_top_tb.sv]
// Self-checking bench for the transmit-abort cause block
`timescale 1ns/1ps
module itac_top_tb;
	import itac_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [31:0] addr_i = '0, wr_data_i = '0, rd_data_o;
	logic wr_en_i = 1'b0, rd_en_i = 1'b0, cmd_pending_i = 1'b0, start_req_i = 1'b0;
	logic next_cmd_read_i = 1'b0, mst_arbitration_lost_flag_i = 1'b0, slv_arbitration_lost_flag_i = 1'b0;
	logic req = 1'b0, ack_want = 1'b0, slow = 1'b0, ack_valid, acked;
	itac_phase_t phase = PH_ADDR7, ack_phase;
	logic restart_allow_o, hs_mode_o, startbyte_sel_o, tx_abort_o, irq_o;
	logic [15:0] abort_cause_o, exp_cause = '0;
	logic [1:0] exp_irq = '0, mask = '0;
	bit addr_ok = 0;
	int mismatches = 0, tests_run = 0, cyc = 0;

	itac_top itac_top_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
		.cmd_pending_i(cmd_pending_i), .start_req_i(start_req_i), .ack_valid_i(ack_valid),
		.ack_phase_i(ack_phase), .acked_i(acked), .next_cmd_read_i(next_cmd_read_i),
		.mst_arbitration_lost_flag_i(mst_arbitration_lost_flag_i), .slv_arbitration_lost_flag_i(slv_arbitration_lost_flag_i),
		.restart_allow_o(restart_allow_o), .hs_mode_o(hs_mode_o),
		.startbyte_sel_o(startbyte_sel_o), .tx_abort_o(tx_abort_o),
		.abort_cause_o(abort_cause_o), .irq_o(irq_o));
	itac_slave_model itac_slave_model_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.req_i(req), .phase_i(phase), .ack_i(ack_want), .slow_i(slow),
		.ack_valid_o(ack_valid), .ack_phase_o(ack_phase), .acked_o(acked));

	always #2 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [31:0] a, logic [31:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge core_clk_i);
		wr_en_i <= 1'b0;
	endtask
	task automatic rchk(logic [31:0] a, logic [31:0] e);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge core_clk_i);
		rd_en_i <= 1'b0;
		#1 chk("rd_data_o", e, rd_data_o);
	endtask
	task automatic look();
		@(posedge core_clk_i);
		#1 chk("abort_cause_o", 32'(exp_cause), 32'(abort_cause_o));
	endtask
	task automatic start();
		@(posedge core_clk_i);
		start_req_i <= 1'b1;
		@(posedge core_clk_i);
		start_req_i <= 1'b0;
		addr_ok = 0;
	endtask
	task automatic xfer(itac_phase_t p, bit a, bit ncr, bit s);
		int b;
		@(posedge core_clk_i);
		phase <= p;
		ack_want <= a;
		slow <= s;
		next_cmd_read_i <= ncr;
		req <= 1'b1;
		@(posedge core_clk_i);
		req <= 1'b0;
		for (int i = 0; i < 8 && !ack_valid; i++) @(posedge core_clk_i);
		case (p)
			PH_ADDR7: b = a ? -1 : 0;
			PH_ADDR10_FIRST: b = a ? -1 : 1;
			PH_ADDR10_SECOND: b = a ? -1 : 2;
			PH_GCALL: b = a ? (ncr ? 5 : -1) : 4;
			PH_STARTBYTE: b = a ? 7 : -1;
			PH_HS_CODE: b = a ? 6 : -1;
			default: b = (!a && addr_ok) ? 3 : -1;
		endcase
		if (a && (p == PH_ADDR7 || p == PH_ADDR10_SECOND)) addr_ok = 1;
		#1 chk("tx_abort_o", 32'(b >= 0 && !exp_cause[b]), 32'(tx_abort_o));
		if (b >= 0) exp_cause[b] = 1'b1;
		if (b >= 0) exp_irq[0] = 1'b1;
		chk("abort_cause_o", 32'(exp_cause), 32'(abort_cause_o));
		chk("irq_o", 32'(|(exp_irq & mask)), 32'(irq_o));
	endtask
	task automatic arb(bit s);
		@(posedge core_clk_i);
		if (s) slv_arbitration_lost_flag_i <= 1'b1;
		else mst_arbitration_lost_flag_i <= 1'b1;
		@(posedge core_clk_i);
		slv_arbitration_lost_flag_i <= 1'b0;
		mst_arbitration_lost_flag_i <= 1'b0;
		exp_cause[BIT_ARBITRATION_LOST_FLAG] = 1'b1;
		exp_irq[IRQ_ARB] = 1'b1;
		#1 chk("abort_cause_o", 32'(exp_cause), 32'(abort_cause_o));
		wr(OFF_CLEAR, 32'h1000);
		exp_cause = '0;
		look();
	endtask

	initial begin
		void'($urandom(50567));
		repeat (20) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		rchk(OFF_CONFIG, 32'h0);
		rchk(OFF_TARGET, 32'h0);
		rchk(OFF_CLEAR, 32'h0);
		rchk(OFF_IRQ_STAT, 32'h0);
		rchk(OFF_IRQ_MASK, 32'h0);
		rchk(OFF_CAUSE, 32'h0);
		rchk(32'h5000_1390, 32'h0);
		wr(OFF_CAUSE, 32'hffff);
		wr(32'h5000_1390, 32'hffff);
		rchk(OFF_CAUSE, 32'h0);
		$display("test reset_and_access done");
		start();
		xfer(PH_DATA, 1'b0, 1'b0, 1'b1);
		for (int p = 0; p < 7; p++) begin
			for (int a = 0; a < 2; a++) xfer(itac_phase_t'(p), a[0], 1'b1, a[0]);
			if (p == 3) wr(OFF_IRQ_MASK, 32'h3);
			if (p == 3) mask = 2'h3;
		end
		rchk(OFF_CAUSE, 32'(exp_cause));
		wr(OFF_CLEAR, 32'h13ff);
		exp_cause = '0;
		look();
		$display("test each_cause done");
		@(posedge core_clk_i);
		cmd_pending_i <= 1'b1;
		wr(OFF_TARGET, 32'h0c00);
		#1 chk("startbyte_sel_o", 32'h1, 32'(startbyte_sel_o));
		exp_cause[BIT_STARTBYTE_NO_RESTART] = 1'b1;
		look();
		wr(OFF_CLEAR, 32'h200);
		#1 chk("abort_cause_o", 32'h0, 32'(abort_cause_o));
		look();
		wr(OFF_CONFIG, 32'h20);
		#1 chk("restart_allow_o", 32'h1, 32'(restart_allow_o));
		wr(OFF_CLEAR, 32'h200);
		exp_cause = '0;
		look();
		wr(OFF_TARGET, 32'h0);
		wr(OFF_CONFIG, 32'h26);
		#1 chk("hs_mode_o", 32'h1, 32'(hs_mode_o));
		look();
		wr(OFF_CONFIG, 32'h6);
		exp_cause[BIT_HS_NO_RESTART] = 1'b1;
		look();
		// Cause still present: the set beats the clear for flag 8
		wr(OFF_CLEAR, 32'h100);
		look();
		@(posedge core_clk_i);
		cmd_pending_i <= 1'b0;
		wr(OFF_CLEAR, 32'h100);
		exp_cause = '0;
		look();
		$display("test level_causes done");
		arb(1'b0);
		arb(1'b1);
		rchk(OFF_IRQ_STAT, 32'(exp_irq));
		wr(OFF_IRQ_STAT, 32'h3);
		exp_irq = '0;
		#1 chk("irq_o", 32'h0, 32'(irq_o));
		$display("test arbitration_and_irq done");
		repeat (30) begin
			if ($urandom_range(3) == 0) start();
			xfer(itac_phase_t'($urandom_range(6)), 1'($urandom), 1'($urandom), 1'($urandom));
		end
		rchk(OFF_CAUSE, 32'(exp_cause));
		$display("test random_traffic done");
		end_sim();
	end
endmodule
